/* design/tx_rx_gain_scaling.sv */
`timescale 1ns/10ps
module tx_rx_gain_scaling (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_in_valid,
   input wire logic signed [15:0] tx_in_data,
   output logic tx_out_valid,
   output logic signed [15:0] tx_out_data,
   output logic signed [7:0] tx_analog_gain_db10,
   input wire logic rx_in_valid,
   input wire logic signed [15:0] rx_in_data,
   output logic rx_out_valid,
   output logic signed [15:0] rx_out_data,
   output logic signed [7:0] rx_analog_gain_db10
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Factor of one bit, unity when clear
   function automatic logic [15:0] bit_factor(input logic [2:0] idx, input logic on);
      logic [15:0] f;
      f = gain_pkg::FACTOR_ONE;
      if (on) begin
         case (idx)
            3'h7: f = gain_pkg::FACTOR_B7;
            3'h6: f = gain_pkg::FACTOR_B6;
            3'h5: f = gain_pkg::FACTOR_B5;
            3'h4: f = gain_pkg::FACTOR_B4;
            3'h3: f = gain_pkg::FACTOR_B3;
            3'h2: f = gain_pkg::FACTOR_B2;
            3'h1: f = gain_pkg::FACTOR_B1;
            default: f = gain_pkg::FACTOR_B0;
         endcase
      end
      return f;
   endfunction : bit_factor

   // Saturate a wide product down to a sample
   function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
      logic signed [15:0] r;
      r = v[15:0];
      if (v > 36'sd32767) begin
         r = gain_pkg::SAMPLE_MAX;
      end else if (v < -36'sd32768) begin
         r = gain_pkg::SAMPLE_MIN;
      end
      return r;
   endfunction : sat16

   // One stage: sample times factor, back to Q0 with saturation
   function automatic logic signed [15:0] scale(input logic signed [15:0] s,
                                                input logic [15:0] f);
      logic signed [35:0] p;
      p = 36'(s) * $signed({20'h00000, f});
      return sat16(p >>> gain_pkg::FRAC_BITS);
   endfunction : scale

   // Analog transmit decode
   function automatic logic signed [7:0] tx_decode(input logic [2:0] c);
      logic signed [7:0] g;
      case (c)
         3'b000: g = gain_pkg::TX_GAIN_000;
         3'b001: g = gain_pkg::TX_GAIN_001;
         3'b010: g = gain_pkg::TX_GAIN_010;
         3'b011: g = gain_pkg::TX_GAIN_011;
         3'b100: g = gain_pkg::TX_GAIN_100;
         3'b101: g = gain_pkg::TX_GAIN_101;
         3'b110: g = gain_pkg::TX_GAIN_110;
         default: g = gain_pkg::TX_GAIN_111;
      endcase
      return g;
   endfunction : tx_decode

   // Analog receive decode
   function automatic logic signed [7:0] rx_decode(input logic [1:0] c);
      logic signed [7:0] g;
      case (c)
         2'b00: g = gain_pkg::RX_GAIN_00;
         2'b01: g = gain_pkg::RX_GAIN_01;
         2'b10: g = gain_pkg::RX_GAIN_10;
         default: g = gain_pkg::RX_GAIN_11;
      endcase
      return g;
   endfunction : rx_decode

   // ------------------------------------------------------------
   // Register file over APB
   // ------------------------------------------------------------
   logic [7:0] tx_digital_gain_reg, tx_digital_gain_next;
   logic [7:0] rx_digital_gain_reg, rx_digital_gain_next;
   logic [7:0] analog_gain_control_reg, analog_gain_control_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic access;
   logic hit;

   assign access = psel && penable && !pready_reg;
   assign hit = (paddr == gain_pkg::TX_DG_OFFSET) || (paddr == gain_pkg::RX_DG_OFFSET) ||
                (paddr == gain_pkg::ANALOG_OFFSET);

   // Decode, write and read mux
   always_comb begin
      tx_digital_gain_next = tx_digital_gain_reg;
      rx_digital_gain_next = rx_digital_gain_reg;
      analog_gain_control_next = analog_gain_control_reg;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (access) begin
         pready_next = 1'b1;
         pslverr_next = !hit;
         prdata_next = 32'h00000000;
         if (pwrite) begin
            if (paddr == gain_pkg::TX_DG_OFFSET) begin
               tx_digital_gain_next = pwdata[7:0];
            end
            if (paddr == gain_pkg::RX_DG_OFFSET) begin
               rx_digital_gain_next = pwdata[7:0];
            end
            if (paddr == gain_pkg::ANALOG_OFFSET) begin
               analog_gain_control_next = pwdata[7:0];
            end
         end else begin
            if (paddr == gain_pkg::RX_DG_OFFSET) begin
               prdata_next = {24'h000000, rx_digital_gain_reg};
            end
            if (paddr == gain_pkg::ANALOG_OFFSET) begin
               prdata_next = {24'h000000, analog_gain_control_reg};
            end
            // Transmit gain word stays zero on read
         end
      end
   end

   // Register state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_digital_gain_reg <= gain_pkg::TX_DG_RESET;
         rx_digital_gain_reg <= gain_pkg::RX_DG_RESET;
         analog_gain_control_reg <= gain_pkg::ANALOG_RESET;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         tx_digital_gain_reg <= tx_digital_gain_next;
         rx_digital_gain_reg <= rx_digital_gain_next;
         analog_gain_control_reg <= analog_gain_control_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ------------------------------------------------------------
   // Digital gain chains, one stage per bit
   // ------------------------------------------------------------
   logic signed [15:0] tx_stage [0:8];
   logic signed [15:0] rx_stage [0:8];
   logic [7:0] tx_vld_reg, tx_vld_next;
   logic [7:0] rx_vld_reg, rx_vld_next;
   logic signed [15:0] tx_pipe_next [1:8];
   logic signed [15:0] rx_pipe_next [1:8];

   assign tx_stage[0] = tx_in_data;
   assign rx_stage[0] = rx_in_data;

   // Valid chains
   always_comb begin
      tx_vld_next = {tx_vld_reg[6:0], tx_in_valid};
      rx_vld_next = {rx_vld_reg[6:0], rx_in_valid};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_vld_reg <= 8'h00;
         rx_vld_reg <= 8'h00;
      end else begin
         tx_vld_reg <= tx_vld_next;
         rx_vld_reg <= rx_vld_next;
      end
   end

   // Stage k applies bit 8-k; product of all set factors
   genvar k;
   generate
      for (k = 1; k <= 8; k++) begin : g_stage
         always_comb begin
            tx_pipe_next[k] = scale(tx_stage[k-1],
                                    bit_factor(3'(8 - k), tx_digital_gain_reg[8-k]));
            rx_pipe_next[k] = scale(rx_stage[k-1],
                                    bit_factor(3'(8 - k), rx_digital_gain_reg[8-k]));
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               tx_stage[k] <= 16'sh0000;
               rx_stage[k] <= 16'sh0000;
            end else begin
               tx_stage[k] <= tx_pipe_next[k];
               rx_stage[k] <= rx_pipe_next[k];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Outputs and analog decode
   // ------------------------------------------------------------
   logic signed [7:0] tx_ag_reg, tx_ag_next;
   logic signed [7:0] rx_ag_reg, rx_ag_next;

   // Analog settings decoded after the digital stage
   always_comb begin
      tx_ag_next = tx_decode({analog_gain_control_reg[gain_pkg::TX_BOOST_BIT],
                              analog_gain_control_reg[gain_pkg::TX_LEVEL_HI_BIT],
                              analog_gain_control_reg[gain_pkg::TX_LEVEL_LO_BIT]});
      rx_ag_next = rx_decode({analog_gain_control_reg[gain_pkg::RX_GAIN_HI_BIT],
                              analog_gain_control_reg[gain_pkg::RX_GAIN_LO_BIT]});
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ag_reg <= 8'sh00;
         rx_ag_reg <= 8'sh00;
      end else begin
         tx_ag_reg <= tx_ag_next;
         rx_ag_reg <= rx_ag_next;
      end
   end

   // Unity codes give a transparent path
   assign tx_out_data = tx_stage[8];
   assign rx_out_data = rx_stage[8];
   assign tx_out_valid = tx_vld_reg[7];
   assign rx_out_valid = rx_vld_reg[7];
   assign tx_analog_gain_db10 = tx_ag_reg;
   assign rx_analog_gain_db10 = rx_ag_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_tx_read_zero;
      @(posedge clk) disable iff (!rst_n)
         (access && !pwrite && paddr == gain_pkg::TX_DG_OFFSET) |=> (prdata == 32'h00000000);
   endproperty
   a_tx_read_zero: assert property (p_tx_read_zero)
      else $error("transmit gain read not zero");

   property p_rx_readback;
      @(posedge clk) disable iff (!rst_n)
         (access && !pwrite && paddr == gain_pkg::RX_DG_OFFSET)
            |=> (prdata[7:0] == $past(rx_digital_gain_reg));
   endproperty
   a_rx_readback: assert property (p_rx_readback)
      else $error("receive gain readback wrong");

   property p_rx_unity;
      @(posedge clk) disable iff (!rst_n)
         (rx_digital_gain_reg == 8'h00)[*8] ##1 (rx_digital_gain_reg == 8'h00)
            |-> (rx_out_data == $past(rx_in_data, 8));
   endproperty
   a_rx_unity: assert property (p_rx_unity)
      else $error("unity receive gain altered sample");

   // Run of cycles with the quarter code, saturating at the pipe depth
   logic [3:0] quarter_run_reg, quarter_run_next;
   always_comb begin
      quarter_run_next = 4'h0;
      if (tx_digital_gain_reg == 8'h80) begin
         quarter_run_next = (quarter_run_reg == 4'h8) ? 4'h8 : quarter_run_reg + 4'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quarter_run_reg <= 4'h0;
      end else begin
         quarter_run_reg <= quarter_run_next;
      end
   end

   property p_tx_quarter;
      @(posedge clk) disable iff (!rst_n)
         (quarter_run_reg == 4'h8 && tx_digital_gain_reg == 8'h80)
            |-> (tx_out_data == ($past(tx_in_data, 8) >>> 2));
   endproperty
   a_tx_quarter: assert property (p_tx_quarter)
      else $error("bit 7 factor not a quarter");

   property p_tx_decode_unity;
      @(posedge clk) disable iff (!rst_n)
         (analog_gain_control_reg[7:5] == 3'b001) |=> (tx_analog_gain_db10 == 8'sh00);
   endproperty
   a_tx_decode_unity: assert property (p_tx_decode_unity)
      else $error("transmit analog decode wrong");

   property p_rx_decode_unity;
      @(posedge clk) disable iff (!rst_n)
         (analog_gain_control_reg[1:0] == 2'b10) |=> (rx_analog_gain_db10 == 8'sh00);
   endproperty
   a_rx_decode_unity: assert property (p_rx_decode_unity)
      else $error("receive analog decode wrong");

   property p_valid_latency;
      @(posedge clk) disable iff (!rst_n)
         tx_in_valid |-> ##8 tx_out_valid;
   endproperty
   a_valid_latency: assert property (p_valid_latency)
      else $error("transmit latency not eight");

   property p_saturate;
      @(posedge clk) disable iff (!rst_n)
         (tx_digital_gain_reg == 8'h20 && tx_in_data == 16'sh7FFF) ##1
            (tx_digital_gain_reg == 8'h20)[*7] |=> (tx_out_data == gain_pkg::SAMPLE_MAX);
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("overflow did not saturate");

endmodule : tx_rx_gain_scaling

/* design/gain_pkg.sv */
// What this block does
// - The transmit analog code {boost, level select} is decoded to a nominal gain in tenths of dB per the fixed table.
// - The two-bit receive analog code decodes to -6, -3, 0 or +3 dB, code 10 being unity.
// - The receive digital gain byte is held in bits 7 to 0 of the word at offset 0x24 (index 0x09).
// - Each set bit of a digital gain byte multiplies the sample by its own factor, clear bits by one.
// - Default transmit settings give unity (0 dB), and code 00000010 scales by 1.03125, about +0.27 dB.
// - With unity receive settings the receive path passes the sample unchanged in level.
// - In transmit the digital stage comes first, then the analog boost and level decode.
// - The net digital gain is the product of all set bit factors, an all-zero byte giving unity.
// - A read of the transmit digital gain word returns zero whatever was written.
package gain_pkg;
   // Register index, byte address is four times the index
   localparam logic [9:0] TX_DG_INDEX = 10'h008;
   localparam logic [9:0] RX_DG_INDEX = 10'h009;
   localparam logic [9:0] ANALOG_INDEX = 10'h014;
   localparam logic [11:0] TX_DG_OFFSET = {TX_DG_INDEX, 2'b00};
   localparam logic [11:0] RX_DG_OFFSET = {RX_DG_INDEX, 2'b00};
   localparam logic [11:0] ANALOG_OFFSET = {ANALOG_INDEX, 2'b00};
   localparam logic [7:0] TX_DG_RESET = 8'h00;
   localparam logic [7:0] RX_DG_RESET = 8'h00;
   localparam logic [7:0] ANALOG_RESET = 8'h22;
   localparam int TX_BOOST_BIT = 7;
   localparam int TX_LEVEL_HI_BIT = 6;
   localparam int TX_LEVEL_LO_BIT = 5;
   localparam int RX_GAIN_HI_BIT = 1;
   localparam int RX_GAIN_LO_BIT = 0;
   // Bit factors in Q2.14, bit 7 first down to bit 0
   localparam logic [15:0] FACTOR_B7 = 16'h1000;
   localparam logic [15:0] FACTOR_B6 = 16'h2000;
   localparam logic [15:0] FACTOR_B5 = 16'h6000;
   localparam logic [15:0] FACTOR_B4 = 16'h5000;
   localparam logic [15:0] FACTOR_B3 = 16'h4800;
   localparam logic [15:0] FACTOR_B2 = 16'h4400;
   localparam logic [15:0] FACTOR_B1 = 16'h4200;
   localparam logic [15:0] FACTOR_B0 = 16'h4100;
   localparam logic [15:0] FACTOR_ONE = 16'h4000;
   localparam int FRAC_BITS = 14;
   localparam logic signed [15:0] SAMPLE_MAX = 16'sh7FFF;
   localparam logic signed [15:0] SAMPLE_MIN = -16'sh8000;
   // Nominal analog gains in tenths of dB
   localparam logic signed [7:0] TX_GAIN_000 = 8'sh1E;
   localparam logic signed [7:0] TX_GAIN_001 = 8'sh00;
   localparam logic signed [7:0] TX_GAIN_010 = -8'sh28;
   localparam logic signed [7:0] TX_GAIN_011 = -8'sh50;
   localparam logic signed [7:0] TX_GAIN_100 = 8'sh3C;
   localparam logic signed [7:0] TX_GAIN_101 = 8'sh3C;
   localparam logic signed [7:0] TX_GAIN_110 = 8'sh14;
   localparam logic signed [7:0] TX_GAIN_111 = -8'sh14;
   localparam logic signed [7:0] RX_GAIN_00 = -8'sh3C;
   localparam logic signed [7:0] RX_GAIN_01 = -8'sh1E;
   localparam logic signed [7:0] RX_GAIN_10 = 8'sh00;
   localparam logic signed [7:0] RX_GAIN_11 = 8'sh1E;
endpackage : gain_pkg

/* verif/pcm_source.sv */
`timescale 1ns/10ps
module pcm_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic send,
   input wire logic signed [15:0] value,
   output logic valid,
   output logic signed [15:0] data
);
   // ------------------------------------------------------------
   // Sample launch towards the block
   // ------------------------------------------------------------
   logic valid_next;
   logic signed [15:0] data_next;
   // Idle data flips each cycle so a stale sample never looks valid
   always_comb begin
      valid_next = send;
      data_next = send ? value : ~data;
   end
   // Launch register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid <= 1'b0;
         data <= 16'h0000;
      end else begin
         valid <= valid_next;
         data <= data_next;
      end
   end
endmodule : pcm_source

/* verif/tx_rx_gain_scaling_test.sv */
`timescale 1ns/10ps
module tx_rx_gain_scaling_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic tx_send, rx_send, tx_in_valid, rx_in_valid, tx_out_valid, rx_out_valid;
   logic signed [15:0] tx_value, rx_value, tx_in_data, rx_in_data, tx_out_data, rx_out_data;
   logic signed [7:0] tx_analog_gain_db10, rx_analog_gain_db10;
   logic signed [15:0] tx_q[$], rx_q[$];
   int tx_t[$], rx_t[$];
   int cyc, bad_count, n_checks;
   tx_rx_gain_scaling u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
      .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
      .tx_analog_gain_db10(tx_analog_gain_db10), .rx_in_valid(rx_in_valid),
      .rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
      .rx_analog_gain_db10(rx_analog_gain_db10));
   pcm_source u_tx_src (.clk(clk), .rst_n(rst_n), .send(tx_send), .value(tx_value),
      .valid(tx_in_valid), .data(tx_in_data));
   pcm_source u_rx_src (.clk(clk), .rst_n(rst_n), .send(rx_send), .value(rx_value),
      .valid(rx_in_valid), .data(rx_in_data));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bit factors in Q14, index is the bit, stages run bit 7 down to 0
   function automatic logic signed [15:0] scale(input logic [7:0] code,
                                                input logic signed [15:0] s);
      int f [8] = '{16640, 16896, 17408, 18432, 20480, 24576, 8192, 4096};
      longint p;
      p = s;
      for (int b = 7; b >= 0; b--) begin
         if (code[b]) begin
            p = (p * f[b]) >>> 14;
            p = (p > 32767) ? 32767 : ((p < -32768) ? -32768 : p);
         end
      end
      return p[15:0];
   endfunction : scale
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // One sample per edge, held valid across back to back calls
   task automatic send(input logic rx, input logic [7:0] code, input logic signed [15:0] s);
      if (rx) begin
         rx_send <= 1'b1;
         rx_value <= s;
         rx_q.push_back(scale(code, s));
      end else begin
         tx_send <= 1'b1;
         tx_value <= s;
         tx_q.push_back(scale(code, s));
      end
      @(posedge clk);
   endtask : send
   task automatic drain();
      int n;
      n = 0;
      tx_send <= 1'b0;
      rx_send <= 1'b0;
      while (tx_q.size() + rx_q.size() != 0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(tx_q.size() + rx_q.size(), 32'h0);
   endtask : drain
   // ------------------------------------------------------------
   // Output monitors: value and exact latency
   // ------------------------------------------------------------
   always @(posedge clk) cyc <= cyc + 1;
   always @(negedge clk) begin
      if (tx_in_valid === 1'b1) tx_t.push_back(cyc);
      if (rx_in_valid === 1'b1) rx_t.push_back(cyc);
      if (tx_out_valid === 1'b1) begin
         if (tx_q.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(tx_out_data), 32'(tx_q.pop_front()));
         if (tx_t.size() != 0) chk(cyc - tx_t.pop_front(), 32'h8);
      end
      if (rx_out_valid === 1'b1) begin
         if (rx_q.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(rx_out_data), 32'(rx_q.pop_front()));
         if (rx_t.size() != 0) chk(cyc - rx_t.pop_front(), 32'h8);
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] rd;
      logic err;
      chk(32'(tx_analog_gain_db10), 32'h0);
      chk(32'(rx_analog_gain_db10), 32'h0);
      apb(0, gain_pkg::TX_DG_OFFSET, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(0, gain_pkg::RX_DG_OFFSET, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(0, gain_pkg::ANALOG_OFFSET, 32'h0, rd, err);
      chk(rd, 32'h22);
      apb(1, 12'h030, 32'hFF, rd, err);
      chk({31'h0, err}, 32'h1);
      apb(0, 12'h030, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   endtask : t_reset
   task automatic t_analog();
      logic [31:0] rd;
      logic err;
      int tx_db [8] = '{30, 0, -40, -80, 60, 60, 20, -20};
      int rx_db [4] = '{-60, -30, 0, 30};
      for (int i = 0; i < 8; i++) begin
         apb(1, gain_pkg::ANALOG_OFFSET, {24'h0, i[2:0], 3'b000, i[1:0]}, rd, err);
         apb(0, gain_pkg::ANALOG_OFFSET, 32'h0, rd, err);
         chk(rd, {24'h0, i[2:0], 3'b000, i[1:0]});
         chk(32'(tx_analog_gain_db10), tx_db[i]);
         chk(32'(rx_analog_gain_db10), rx_db[i % 4]);
      end
      apb(1, gain_pkg::ANALOG_OFFSET, 32'h22, rd, err);
   endtask : t_analog
   task automatic t_tx();
      logic [31:0] rd;
      logic err;
      logic [7:0] codes [6] = '{8'h00, 8'h02, 8'h6C, 8'hFF, 8'h20, 8'h80};
      logic [15:0] smp [4] = '{16'h4000, 16'h8000, 16'h7FFF, 16'hEDCC};
      for (int c = 0; c < 6; c++) begin
         apb(1, gain_pkg::TX_DG_OFFSET, {24'hA5A5A5, codes[c]}, rd, err);
         chk({31'h0, err}, 32'h0);
         apb(0, gain_pkg::TX_DG_OFFSET, 32'h0, rd, err);
         chk(rd, 32'h0);
         for (int j = 0; j < 4; j++) begin
            send(0, codes[c], smp[j]);
         end
         drain();
      end
   endtask : t_tx
   task automatic t_rx();
      logic [31:0] rd;
      logic err;
      logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h81, 8'hFF};
      logic [15:0] smp [3] = '{16'h7FFF, 16'h8001, 16'h0123};
      apb(1, gain_pkg::ANALOG_OFFSET, 32'h22, rd, err);
      for (int c = 0; c < 4; c++) begin
         apb(1, gain_pkg::RX_DG_OFFSET, {24'h5A5A5A, codes[c]}, rd, err);
         apb(0, gain_pkg::RX_DG_OFFSET, 32'h0, rd, err);
         chk(rd, {24'h0, codes[c]});
         for (int j = 0; j < 3; j++) begin
            send(1, codes[c], smp[j]);
         end
         drain();
      end
   endtask : t_rx
   // ------------------------------------------------------------
   // Clock, sequence, watchdog
   // ------------------------------------------------------------
   task automatic end_sim();
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tx_send = 1'b0;
      rx_send = 1'b0;
      tx_value = 16'h0000;
      rx_value = 16'h0000;
      cyc = 0;
      bad_count = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_analog();
      t_tx();
      t_rx();
      end_sim();
   end
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule : tx_rx_gain_scaling_test
